// File: logic/fbm_pkg.sv
// Purpose: shared constants, carriers and helpers of the fifo bus-matching block
// Assumes: both ports run on one clock
// Notes: size codes are {size_sel1, size_sel0}
package fbm_pkg;

  localparam int WORD_W = 36;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;

  localparam logic [6:0] FILL_MAX = 7'h40;
  localparam logic [6:0] OFFSET_HH = 7'h10;
  localparam logic [6:0] OFFSET_HL = 7'h0C;
  localparam logic [6:0] OFFSET_LH = 7'h08;
  localparam logic [6:0] OFFSET_LL = 7'h04;
  localparam logic [6:0] RST_OFFSET = OFFSET_LL;

  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_MAIL = 2'h3;

  localparam logic [2:0] PARTS_LONG = 3'h1;
  localparam logic [2:0] PARTS_WORD = 3'h2;
  localparam logic [2:0] PARTS_BYTE = 3'h4;

  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_REVERSE = 2'h1;
  localparam logic [1:0] SWAP_HALVES = 2'h2;
  localparam logic [1:0] SWAP_PAIRS = 2'h3;

  localparam logic [35:0] RST_WORD = 36'h000000000;

  typedef struct packed {
    logic chip_select_n;
    logic write_not_read;
    logic xfer_gate;
    logic mailbox_select;
    logic [35:0] bus;
  } fbm_port_a_s;

  typedef struct packed {
    logic chip_select_n;
    logic write_not_read;
    logic xfer_gate;
    logic size_sel1;
    logic size_sel0;
    logic big_endian_select_n;
    logic swap_mode_sel1;
    logic swap_mode_sel0;
    logic [35:0] bus;
  } fbm_port_b_s;

  typedef struct packed {
    logic fifo_empty_n;
    logic fifo_full_n;
    logic fifo_almost_empty_n;
    logic fifo_almost_full_n;
    logic a_to_b_mail_pending_n;
    logic b_to_a_mail_pending_n;
  } fbm_flags_s;

  // bytes named A..D from most significant; bits inside a byte keep order
  function automatic logic [35:0] fbm_swap(input logic [35:0] w, input logic [1:0] mode);
    logic [35:0] r;
    r = w;
    unique case (mode)
      SWAP_NONE: r = w;
      SWAP_REVERSE: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      SWAP_HALVES: r = {w[17:0], w[35:18]};
      SWAP_PAIRS: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
    endcase
    return r;
  endfunction : fbm_swap

endpackage : fbm_pkg

// File: logic/fbm_fifo_bus_match.sv
// Purpose: 64 x 36 fifo with offset flags, two mailboxes and port-b bus matching
// Assumes: port a and port b controls are synchronous to clk
// Notes: data outputs are registered, one clock behind the selects
`timescale 1ns/100ps

module fbm_fifo_bus_match (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // port a controls and bus
  input wire fbm_pkg::fbm_port_a_s port_a_ctl,
  output fbm_pkg::fbm_port_a_s port_a_unused_never,
  // port b controls and bus
  input wire fbm_pkg::fbm_port_b_s port_b_ctl,
  // offset presets
  input wire logic offset_choice0,
  input wire logic offset_choice1,
  // data drive back onto the buses
  output logic [35:0] port_a_drive,
  output logic port_a_drive_en,
  output logic [35:0] port_b_drive,
  output logic port_b_drive_en,
  // status
  output fbm_pkg::fbm_flags_s flags
);

  // decoded port operations
  logic a_sel_wr;
  logic a_sel_rd;
  logic b_sel_wr;
  logic b_sel_rd;
  logic b_mail_sel;
  logic fifo_wr;
  logic fifo_rd;
  logic fetch;
  logic mail_ab_wr;
  logic mail_ba_wr;
  logic mail_ab_rd;
  logic mail_ba_rd;

  // fifo and flag state
  logic [35:0] mem [fbm_pkg::DEPTH];
  logic [5:0] wr_ptr_r, wr_ptr_nxt;
  logic [5:0] rd_ptr_r, rd_ptr_nxt;
  logic [6:0] fill_r, fill_nxt;
  logic [6:0] offset_r, offset_nxt;
  logic offset_done_r, offset_done_nxt;
  logic almost_empty_s1_r, almost_empty_s1_nxt;
  logic almost_full_s1_r, almost_full_s1_nxt;
  fbm_pkg::fbm_flags_s flags_nxt;

  // mailbox state
  logic [35:0] mail_ab_r, mail_ab_nxt;
  logic [35:0] mail_ba_r, mail_ba_nxt;
  logic mail_ab_pend_n_r, mail_ab_pend_n_nxt;
  logic mail_ba_pend_n_r, mail_ba_pend_n_nxt;

  // bus matching state
  logic [1:0] size_r, size_nxt;
  logic big_r, big_nxt;
  logic [1:0] cur_size_r, cur_size_nxt;
  logic cur_big_r, cur_big_nxt;
  logic [35:0] hold_r, hold_nxt;
  logic [1:0] part_r, part_nxt;
  logic [2:0] left_r, left_nxt;
  logic [35:0] out_r, out_nxt;

  // output drive registers
  logic [35:0] a_drive_nxt;
  logic [35:0] b_drive_nxt;
  logic a_en_nxt;
  logic b_en_nxt;

  assign port_a_unused_never = '0;

  always_comb begin
    a_sel_wr = !port_a_ctl.chip_select_n && port_a_ctl.write_not_read && port_a_ctl.xfer_gate;
    a_sel_rd = !port_a_ctl.chip_select_n && !port_a_ctl.write_not_read && port_a_ctl.xfer_gate;
    b_sel_wr = !port_b_ctl.chip_select_n && port_b_ctl.write_not_read && port_b_ctl.xfer_gate;
    b_sel_rd = !port_b_ctl.chip_select_n && !port_b_ctl.write_not_read && port_b_ctl.xfer_gate;
    b_mail_sel = port_b_ctl.size_sel1 && port_b_ctl.size_sel0;
    fifo_wr = a_sel_wr && !port_a_ctl.mailbox_select && (fill_r != fbm_pkg::FILL_MAX);
    mail_ab_wr = a_sel_wr && port_a_ctl.mailbox_select && mail_ab_pend_n_r;
    mail_ba_wr = b_sel_wr && b_mail_sel && mail_ba_pend_n_r;
    mail_ab_rd = b_sel_rd && b_mail_sel;
    mail_ba_rd = a_sel_rd && port_a_ctl.mailbox_select;
    // a size change forces a fresh fetch
    fetch = (left_r == 3'h0) || (size_r != cur_size_r) || (big_r != cur_big_r);
    fifo_rd = b_sel_rd && !b_mail_sel && (!fetch || (fill_r != 7'h00));
  end

  // fifo pointers, fill count, offset and flags
  always_comb begin
    wr_ptr_nxt = wr_ptr_r + {5'h00, fifo_wr};
    rd_ptr_nxt = rd_ptr_r + {5'h00, fifo_rd && fetch};
    fill_nxt = fill_r + {6'h00, fifo_wr} - {6'h00, fifo_rd && fetch};
    offset_nxt = offset_r;
    offset_done_nxt = 1'b1;
    if (!offset_done_r) begin
      unique case ({offset_choice1, offset_choice0})
        2'h3: offset_nxt = fbm_pkg::OFFSET_HH;
        2'h2: offset_nxt = fbm_pkg::OFFSET_HL;
        2'h1: offset_nxt = fbm_pkg::OFFSET_LH;
        2'h0: offset_nxt = fbm_pkg::OFFSET_LL;
      endcase
    end
    almost_empty_s1_nxt = fill_r > offset_r;
    almost_full_s1_nxt = fill_r < (fbm_pkg::FILL_MAX - offset_r);
    flags_nxt.fifo_almost_empty_n = almost_empty_s1_r;
    flags_nxt.fifo_almost_full_n = almost_full_s1_r;
    flags_nxt.fifo_empty_n = (fill_nxt != 7'h00) || (left_nxt != 3'h0);
    flags_nxt.fifo_full_n = fill_nxt != fbm_pkg::FILL_MAX;
    flags_nxt.a_to_b_mail_pending_n = mail_ab_pend_n_nxt;
    flags_nxt.b_to_a_mail_pending_n = mail_ba_pend_n_nxt;
  end

  always_ff @(posedge clk) begin
    if (fifo_wr) begin
      mem[wr_ptr_r] <= port_a_ctl.bus;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= 6'h00;
      rd_ptr_r <= 6'h00;
      fill_r <= 7'h00;
      offset_r <= fbm_pkg::RST_OFFSET;
      offset_done_r <= 1'b0;
      almost_empty_s1_r <= 1'b0;
      almost_full_s1_r <= 1'b1;
      flags <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      fill_r <= fill_nxt;
      offset_r <= offset_nxt;
      offset_done_r <= offset_done_nxt;
      almost_empty_s1_r <= almost_empty_s1_nxt;
      almost_full_s1_r <= almost_full_s1_nxt;
      flags <= flags_nxt;
    end
  end

  // mailboxes
  always_comb begin
    mail_ab_nxt = mail_ab_r;
    mail_ba_nxt = mail_ba_r;
    mail_ab_pend_n_nxt = mail_ab_pend_n_r;
    mail_ba_pend_n_nxt = mail_ba_pend_n_r;
    // contents change only on accepted writes
    if (mail_ab_wr) begin
      mail_ab_nxt = port_a_ctl.bus;
    end
    if (mail_ba_wr) begin
      mail_ba_nxt = port_b_ctl.bus;
    end
    // write lowers flag; writes blocked while low
    if (mail_ab_rd) begin
      mail_ab_pend_n_nxt = 1'b1;
    end
    if (mail_ab_wr) begin
      mail_ab_pend_n_nxt = 1'b0;
    end
    if (mail_ba_rd) begin
      mail_ba_pend_n_nxt = 1'b1;
    end
    if (mail_ba_wr) begin
      mail_ba_pend_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mail_ab_r <= fbm_pkg::RST_WORD;
      mail_ba_r <= fbm_pkg::RST_WORD;
      mail_ab_pend_n_r <= 1'b1;
      mail_ba_pend_n_r <= 1'b1;
    end else begin
      mail_ab_r <= mail_ab_nxt;
      mail_ba_r <= mail_ba_nxt;
      mail_ab_pend_n_r <= mail_ab_pend_n_nxt;
      mail_ba_pend_n_r <= mail_ba_pend_n_nxt;
    end
  end

  // bus matching on port b reads
  always_comb begin
    logic [35:0] word;
    logic [1:0] k;
    word = hold_r;
    k = part_r;
    size_nxt = size_r;
    big_nxt = big_r;
    // selects registered; mailbox codes keep old size
    if (!b_mail_sel) begin
      size_nxt = {port_b_ctl.size_sel1, port_b_ctl.size_sel0};
      big_nxt = !port_b_ctl.big_endian_select_n;
    end
    cur_size_nxt = cur_size_r;
    cur_big_nxt = cur_big_r;
    hold_nxt = hold_r;
    part_nxt = part_r;
    left_nxt = left_r;
    out_nxt = out_r;
    if (fifo_rd) begin
      if (fetch) begin
        word = fbm_pkg::fbm_swap(mem[rd_ptr_r],
                                 {port_b_ctl.swap_mode_sel1, port_b_ctl.swap_mode_sel0});
        k = 2'h0;
        hold_nxt = word;
        cur_size_nxt = size_r;
        cur_big_nxt = big_r;
        unique case (size_r)
          fbm_pkg::SIZE_WORD: left_nxt = fbm_pkg::PARTS_WORD;
          fbm_pkg::SIZE_BYTE: left_nxt = fbm_pkg::PARTS_BYTE;
          default: left_nxt = fbm_pkg::PARTS_LONG;
        endcase
      end
      // one part per read, rest kept aside
      left_nxt = left_nxt - 3'h1;
      part_nxt = k + 2'h1;
      unique case (size_r)
        fbm_pkg::SIZE_WORD: begin
          if (big_r) begin
            out_nxt[35:18] = k[0] ? word[17:0] : word[35:18];
          end else begin
            out_nxt[17:0] = k[0] ? word[35:18] : word[17:0];
          end
        end
        fbm_pkg::SIZE_BYTE: begin
          if (big_r) begin
            out_nxt[35:27] = word[(6'd27 - 6'd9 * {4'h0, k}) +: 9];
          end else begin
            out_nxt[8:0] = word[(6'd9 * {4'h0, k}) +: 9];
          end
        end
        default: out_nxt = word;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      size_r <= fbm_pkg::SIZE_LONG;
      big_r <= 1'b0;
      cur_size_r <= fbm_pkg::SIZE_LONG;
      cur_big_r <= 1'b0;
      hold_r <= fbm_pkg::RST_WORD;
      part_r <= 2'h0;
      left_r <= 3'h0;
      out_r <= fbm_pkg::RST_WORD;
    end else begin
      size_r <= size_nxt;
      big_r <= big_nxt;
      cur_size_r <= cur_size_nxt;
      cur_big_r <= cur_big_nxt;
      hold_r <= hold_nxt;
      part_r <= part_nxt;
      left_r <= left_nxt;
      out_r <= out_nxt;
    end
  end

  // bus drivers, registered
  always_comb begin
    a_en_nxt = !port_a_ctl.chip_select_n && !port_a_ctl.write_not_read;
    a_drive_nxt = mail_ba_nxt;
    b_en_nxt = !port_b_ctl.chip_select_n && !port_b_ctl.write_not_read;
    // mailbox when both size selects high
    b_drive_nxt = b_mail_sel ? mail_ab_nxt : out_nxt;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_drive <= fbm_pkg::RST_WORD;
      port_a_drive_en <= 1'b0;
      port_b_drive <= fbm_pkg::RST_WORD;
      port_b_drive_en <= 1'b0;
    end else begin
      port_a_drive <= a_drive_nxt;
      port_a_drive_en <= a_en_nxt;
      port_b_drive <= b_drive_nxt;
      port_b_drive_en <= b_en_nxt;
    end
  end

endmodule : fbm_fifo_bus_match

// File: tb/fbm_pa_model.sv
// Purpose: port-a bus master model for the fifo bus-matching bench
// Assumes: one transfer per call, changed just after a rising edge
// Notes: a released bus shows the inverse of the last word
`timescale 1ns/100ps
module fbm_pa_model (
  // clock
  input wire logic clk,
  // port a request
  output fbm_pkg::fbm_port_a_s port_a_ctl
);
  initial port_a_ctl = {1'b1, 39'h0};
  // one gated transfer, held until the taking edge
  task automatic op(input logic wnr, input logic mb, input logic [35:0] d);
    @(posedge clk);
    port_a_ctl <= '{1'b0, wnr, 1'b1, mb, d};
    @(posedge clk);
    port_a_ctl <= '{1'b1, 1'b0, 1'b0, 1'b0, ~d};
  endtask : op
endmodule : fbm_pa_model

// File: tb/fbm_fifo_bus_match_props.sv
// Purpose: port-level checks of the fifo bus-matching block
// Assumes: single clock, asynchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module fbm_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // port controls
  input wire fbm_pkg::fbm_port_a_s port_a_ctl,
  input wire fbm_pkg::fbm_port_b_s port_b_ctl,
  // outputs
  input wire logic [35:0] port_a_drive,
  input wire logic port_a_drive_en,
  input wire logic port_b_drive_en,
  input wire fbm_pkg::fbm_flags_s flags
);
  logic a_go, b_go, b_mb, a_mw, a_mr, a_fw, b_mw, b_mr, b_fr, ab_n, ba_n;
  logic a_out, b_out;
  assign a_out = !port_a_ctl.chip_select_n && !port_a_ctl.write_not_read;
  assign b_out = !port_b_ctl.chip_select_n && !port_b_ctl.write_not_read;
  assign a_go = !port_a_ctl.chip_select_n && port_a_ctl.xfer_gate;
  assign b_go = !port_b_ctl.chip_select_n && port_b_ctl.xfer_gate;
  assign b_mb = port_b_ctl.size_sel1 && port_b_ctl.size_sel0;
  assign a_mw = a_go && port_a_ctl.write_not_read && port_a_ctl.mailbox_select;
  assign a_mr = a_go && !port_a_ctl.write_not_read && port_a_ctl.mailbox_select;
  assign a_fw = a_go && port_a_ctl.write_not_read && !port_a_ctl.mailbox_select;
  assign b_mw = b_go && port_b_ctl.write_not_read && b_mb;
  assign b_mr = b_go && !port_b_ctl.write_not_read && b_mb;
  assign b_fr = b_go && !port_b_ctl.write_not_read && !b_mb;
  assign ab_n = flags.a_to_b_mail_pending_n;
  assign ba_n = flags.b_to_a_mail_pending_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ab_set_a: assert property (a_mw && ab_n |=> !ab_n)
    else $error("a-b flag not lowered");
  ab_clr_a: assert property (b_mr && !a_mw |=> ab_n)
    else $error("a-b flag not raised");
  ba_set_a: assert property (b_mw && ba_n |=> !ba_n)
    else $error("b-a flag not lowered");
  ba_clr_a: assert property (a_mr && !b_mw |=> ba_n)
    else $error("b-a flag not raised");
  mail_keep_a: assert property (!(b_mw && ba_n) |=> $stable(port_a_drive))
    else $error("b-a mailbox changed");
  ae_empty_a: assert property (!flags.fifo_empty_n |-> !flags.fifo_almost_empty_n)
    else $error("almost-empty high when empty");
  af_full_a: assert property (!flags.fifo_full_n |-> !flags.fifo_almost_full_n)
    else $error("almost-full high when full");
  ae_rise_a: assert property ($rose(flags.fifo_almost_empty_n) |-> $past(a_fw, 3))
    else $error("almost-empty rose off time");
  af_rise_a: assert property ($rose(flags.fifo_almost_full_n) |-> $past(b_fr, 3))
    else $error("almost-full rose off time");
  a_drive_en_a: assert property (port_a_drive_en == $past(a_out))
    else $error("port a drive enable wrong");
  b_drive_en_a: assert property (port_b_drive_en == $past(b_out))
    else $error("port b drive enable wrong");
endmodule : fbm_checker
bind fbm_fifo_bus_match fbm_checker u_chk (.clk, .rst_b, .port_a_ctl, .port_b_ctl,
  .port_a_drive, .port_a_drive_en, .port_b_drive_en, .flags);

// File: tb/fbm_fifo_bus_match_test.sv
// Purpose: self-checking bench of the fifo bus-matching block
// Assumes: one 100 MHz clock for both ports
// Notes: port a is driven through the partner model
`timescale 1ns/100ps
module fbm_fifo_bus_match_test;
  localparam logic [8:0] QA = 9'h1A1;
  localparam logic [8:0] QB = 9'h0B2;
  localparam logic [8:0] QC = 9'h1C3;
  localparam logic [8:0] QD = 9'h0D4;
  localparam logic [35:0] W = {QA, QB, QC, QD};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] ofs = 2'h0;
  fbm_pkg::fbm_port_a_s pa_ctl;
  fbm_pkg::fbm_port_b_s pb = {1'b1, 43'h0};
  logic [35:0] pa_drv;
  logic [35:0] pb_drv;
  fbm_pkg::fbm_flags_s fl;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  fbm_pa_model pa (.clk(clk), .port_a_ctl(pa_ctl));
  fbm_fifo_bus_match dut (.clk(clk), .rst_b(rst_b), .port_a_ctl(pa_ctl),
    .port_a_unused_never(), .port_b_ctl(pb), .offset_choice0(ofs[0]),
    .offset_choice1(ofs[1]), .port_a_drive(pa_drv), .port_a_drive_en(),
    .port_b_drive(pb_drv), .port_b_drive_en(), .flags(fl));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks=%0d fails=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  // hang guard, well above the whole sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [35:0] wd(input int k);
    return {30'h2A5A5A5A, k[5:0]};
  endfunction : wd
  task automatic bop(input logic g, input logic w, input logic [1:0] sz, input logic be_n,
                     input logic [1:0] sw, input logic [35:0] d);
    @(posedge clk);
    pb <= '{1'b0, w, g, sz[1], sz[0], be_n, sw[1], sw[0], d};
  endtask : bop
  task automatic rd(input logic [1:0] sz, input logic be_n, input logic [1:0] sw,
                    input logic [35:0] e);
    bop(1'b1, 1'b0, sz, be_n, sw, ~e);
    bop(1'b0, 1'b0, sz, be_n, sw, e);
    #1 chk(pb_drv, e);
  endtask : rd
  task automatic rst(input logic [1:0] c);
    @(posedge clk);
    rst_b <= 1'b0;
    ofs <= c;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst
  // flag low one edge after the change, high on the second
  task automatic lag(input logic af);
    @(posedge clk);
    #1 chk(af ? fl.fifo_almost_full_n : fl.fifo_almost_empty_n, 36'h0);
    @(posedge clk);
    #1 chk(af ? fl.fifo_almost_full_n : fl.fifo_almost_empty_n, 36'h1);
  endtask : lag
  task automatic s_offsets;
    for (int c = 0; c < 4; c++) begin
      rst(c[1:0]);
      for (int k = 0; k <= 4 + 4 * c; k++)
        pa.op(1'b1, 1'b0, wd(k));
      lag(1'b0);
    end
  endtask : s_offsets
  task automatic s_full;
    for (int k = 17; k < 64; k++)
      pa.op(1'b1, 1'b0, wd(k));
    repeat (3) @(posedge clk);
    #1 chk(fl.fifo_almost_full_n, 36'h0);
    chk(fl.fifo_full_n, 36'h0);
    pa.op(1'b1, 1'b0, 36'h0);
    bop(1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 36'h0);
    for (int k = 0; k < 17; k++)
      rd(2'h0, 1'b0, 2'h0, wd(k));
    lag(1'b1);
    for (int k = 17; k < 64; k++)
      rd(2'h0, 1'b0, 2'h0, wd(k));
    rd(2'h0, 1'b0, 2'h0, wd(63));
    chk(fl.fifo_empty_n, 36'h0);
  endtask : s_full
  task automatic s_swap;
    logic [35:0] e [4];
    e = '{W, {QD, QC, QB, QA}, {QC, QD, QA, QB}, {QB, QA, QD, QC}};
    repeat (4) pa.op(1'b1, 1'b0, W);
    for (int s = 0; s < 4; s++)
      rd(2'h0, 1'b0, s[1:0], e[s]);
  endtask : s_swap
  task automatic s_mail;
    pa.op(1'b1, 1'b1, W);
    pa.op(1'b1, 1'b1, ~W);
    rd(2'h3, 1'b0, 2'h0, W);
    rd(2'h3, 1'b0, 2'h0, W);
    bop(1'b1, 1'b1, 2'h3, 1'b0, 2'h0, ~W);
    bop(1'b1, 1'b1, 2'h3, 1'b0, 2'h0, W);
    bop(1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 36'h0);
    pa.op(1'b0, 1'b1, 36'h0);
    #1 chk(pa_drv, ~W);
  endtask : s_mail
  task automatic s_word;
    logic [35:0] e;
    repeat (3) pa.op(1'b1, 1'b0, W);
    bop(1'b0, 1'b0, 2'h2, 1'b0, 2'h1, 36'h0);
    rd(2'h2, 1'b0, 2'h1, {QD, QC, QD, QC});
    rd(2'h3, 1'b0, 2'h2, W);
    rd(2'h2, 1'b0, 2'h0, {QB, QA, QD, QC});
    rd(2'h2, 1'b0, 2'h0, {QA, QB, QD, QC});
    e = {QA, QB, QD, QC};
    bop(1'b0, 1'b0, 2'h1, 1'b1, 2'h0, 36'h0);
    for (int k = 0; k < 4; k++) begin
      e[8:0] = W[9 * k +: 9];
      rd(2'h1, 1'b1, 2'h0, e);
    end
  endtask : s_word
  // little-endian words, then big-endian bytes of a reversed word
  task automatic s_lanes;
    logic [35:0] e;
    repeat (2) pa.op(1'b1, 1'b0, W);
    bop(1'b0, 1'b0, 2'h2, 1'b1, 2'h0, 36'h0);
    rd(2'h2, 1'b1, 2'h0, W);
    rd(2'h2, 1'b1, 2'h0, {QA, QB, QA, QB});
    e = {QA, QB, QA, QB};
    bop(1'b0, 1'b0, 2'h1, 1'b0, 2'h1, 36'h0);
    for (int k = 0; k < 4; k++) begin
      e[35:27] = W[9 * k +: 9];
      rd(2'h1, 1'b0, 2'h1, e);
    end
  endtask : s_lanes
  initial begin
    s_offsets();
    s_full();
    s_swap();
    s_mail();
    s_word();
    s_lanes();
    end_sim();
  end
endmodule : fbm_fifo_bus_match_test
